/* File: src/bxe_defs.svh */
// Opcode patterns, bank and adjust constants for the byte-op executor.
// Assumes a 16-bit instruction word and a 12-bit file address.
`ifndef BXE_DEFS_SVH
`define BXE_DEFS_SVH
`define BXE_OPC_DEC      6'h01
`define BXE_OPC_INCSZ    6'h0F
`define BXE_OPC_INCSNZ   6'h12
`define BXE_OPC_CLR      7'h35
`define BXE_INSN_KICK    16'h0004
`define BXE_INSN_BCD     16'h0007
`define BXE_ACCESS_BANK  4'h0
`define BXE_BCD_LIMIT    4'h9
`define BXE_BCD_LO_FIX   9'h006
`define BXE_BCD_HI_FIX   9'h060
`define BXE_SKIP_NONE    2'h0
`define BXE_SKIP_ONE     2'h1
`define BXE_SKIP_TWO     2'h2
`endif

/* File: src/bxe_pkg.sv */
// Types shared by the byte-op executor, its datapath and their interface.
// Assumes nothing beyond a SystemVerilog compiler.
package bxe_pkg;
  typedef enum logic [1:0] {PH_DECODE, PH_READ, PH_PROCESS, PH_WRITE}
    bxe_phase_t;
  typedef enum logic [2:0] {OP_NOP, OP_CLR, OP_KICK, OP_BCD, OP_DEC,
                            OP_INCSZ, OP_INCSNZ} bxe_op_t;
  typedef struct packed {
    logic n;
    logic ov;
    logic z;
    logic half_carry;
    logic c;
  } bxe_flags_t;
  typedef struct packed {
    bxe_phase_t  phase;
    bxe_op_t     op;
    logic        dst_file;
    logic [11:0] addr;
    logic [7:0]  opnd;
    bxe_flags_t  fl;
    logic [7:0]  res;
    logic [1:0]  skip;
    logic        flush;
    logic        file_rd;
    logic        file_we;
    logic        w_we;
    logic [7:0]  wdata;
    logic        flags_we;
    bxe_flags_t  flags;
    logic        kick;
    logic        timeout;
    logic        sleep;
  } bxe_state_t;
endpackage

/* File: src/bxe_alu_if.sv */
// Link between the phase sequencer and its datapath.
// Assumes bxe_pkg is compiled first.
`timescale 1ns/100ps
interface bxe_alu_if;
  bxe_pkg::bxe_op_t    op;
  logic [7:0]          opnd;
  bxe_pkg::bxe_flags_t fin;
  logic [7:0]          res;
  bxe_pkg::bxe_flags_t fout;
  modport core (output op, output opnd, output fin,
                input res, input fout);
  modport alu  (input op, input opnd, input fin,
                output res, output fout);
endinterface // bxe_alu_if

/* File: src/bxe_alu.sv */
// Combinational datapath: result and flags of each byte operation.
// Assumes operand and incoming flags are held stable by the sequencer.
`timescale 1ns/100ps
module bxe_alu
  import bxe_pkg::*;
(
  bxe_alu_if.alu alu_if
);
`include "bxe_defs.svh"

  always_comb
  begin
    logic [8:0] sum;
    logic       lo_fix;
    logic       hi_fix;
    sum         = 9'h000;
    lo_fix      = 1'h0;
    hi_fix      = 1'h0;
    alu_if.res  = alu_if.opnd;
    alu_if.fout = alu_if.fin;
    case (alu_if.op)
      OP_CLR:
      begin
        alu_if.res    = 8'h00;
        alu_if.fout.z = 1'h1;
      end
      OP_BCD:
      begin
        // The low fix may carry into the high nibble before it is checked.
        lo_fix = (alu_if.opnd[3:0] > `BXE_BCD_LIMIT) ||
                 alu_if.fin.half_carry;
        sum    = {1'h0, alu_if.opnd} + (lo_fix ? `BXE_BCD_LO_FIX : 9'h000);
        hi_fix = (sum[7:4] > `BXE_BCD_LIMIT) || alu_if.fin.c || sum[8];
        sum    = sum + (hi_fix ? `BXE_BCD_HI_FIX : 9'h000);
        alu_if.res    = sum[7:0];
        alu_if.fout.c = alu_if.fin.c | hi_fix;
      end
      OP_DEC:
      begin
        sum            = {1'h0, alu_if.opnd} + 9'h0FF;
        alu_if.res     = sum[7:0];
        alu_if.fout.c  = sum[8];
        alu_if.fout.half_carry = (alu_if.opnd[3:0] != 4'h0);
        alu_if.fout.n  = sum[7];
        alu_if.fout.ov = (alu_if.opnd == 8'h80);
        alu_if.fout.z  = (sum[7:0] == 8'h00);
      end
      OP_INCSZ, OP_INCSNZ:
      begin
        alu_if.res = alu_if.opnd + 8'h01;
      end
      default:
      begin
        alu_if.res = alu_if.opnd;
      end
    endcase
  end

endmodule // bxe_alu

/* File: src/bxe_exec.sv */
// Four-phase executor for clear, watchdog kick, BCD adjust, decrement and
// increment-with-skip. Assumes the register file answers a read within the
// read phase and that the fetch unit flags a two-word next instruction.
`timescale 1ns/100ps
module bxe_exec
  import bxe_pkg::*;
(
  // Clock and reset.
  input  wire logic                ref_clk_in,
  input  wire logic                rstn_in,
  // Fetched instruction.
  input  wire logic [15:0]         instr_in,
  input  wire logic                instr_valid_in,
  input  wire logic                next_two_word_in,
  // Core state read by the executor.
  input  wire logic [3:0]          bank_select_in,
  input  wire logic [7:0]          w_in,
  input  wire logic [7:0]          file_rdata_in,
  input  wire bxe_pkg::bxe_flags_t flags_in,
  // File register access.
  output logic [11:0]              file_addr_out,
  output logic                     file_rd_out,
  output logic                     file_we_out,
  output logic [7:0]               file_wdata_out,
  // Accumulator and status write-back.
  output logic                     w_we_out,
  output logic [7:0]               w_wdata_out,
  output logic                     flags_we_out,
  output bxe_pkg::bxe_flags_t      flags_out,
  // Watchdog and sequencing.
  output logic                     watchdog_clear_out,
  output logic                     timeout_status_out,
  output logic                     sleep_status_out,
  output logic                     flush_out,
  output bxe_pkg::bxe_phase_t      phase_out
);
`include "bxe_defs.svh"

  bxe_state_t s_q;
  bxe_state_t s_d;
  bxe_alu_if  alu_if ();

  bxe_alu u_alu (
    .alu_if (alu_if.alu)
  );

  assign alu_if.op   = s_q.op;
  assign alu_if.opnd = s_q.opnd;
  assign alu_if.fin  = s_q.fl;

  always_comb
  begin
    bxe_op_t    op;
    logic       is_inc;
    logic [1:0] nskip;
    op     = OP_NOP;
    is_inc = (s_q.op == OP_INCSZ) || (s_q.op == OP_INCSNZ);
    nskip  = `BXE_SKIP_NONE;
    s_d          = s_q;
    s_d.file_rd  = 1'h0;
    s_d.file_we  = 1'h0;
    s_d.w_we     = 1'h0;
    s_d.flags_we = 1'h0;
    s_d.kick     = 1'h0;
    case (s_q.phase)
      PH_DECODE:
      begin
        // A flushed cycle discards the fetched word and idles.
        if (!s_q.flush && instr_valid_in)
        begin
          if (instr_in == `BXE_INSN_KICK)
            op = OP_KICK;
          else if (instr_in == `BXE_INSN_BCD)
            op = OP_BCD;
          else if (instr_in[15:9] == `BXE_OPC_CLR)
            op = OP_CLR;
          else if (instr_in[15:10] == `BXE_OPC_DEC)
            op = OP_DEC;
          else if (instr_in[15:10] == `BXE_OPC_INCSZ)
            op = OP_INCSZ;
          else if (instr_in[15:10] == `BXE_OPC_INCSNZ)
            op = OP_INCSNZ;
        end
        s_d.op       = op;
        s_d.dst_file = instr_in[9];
        s_d.addr     = {instr_in[8] ? bank_select_in : `BXE_ACCESS_BANK,
                        instr_in[7:0]};
        s_d.file_rd  = (op == OP_CLR) || (op == OP_DEC) ||
                       (op == OP_INCSZ) || (op == OP_INCSNZ);
        s_d.phase    = PH_READ;
      end
      PH_READ:
      begin
        s_d.opnd  = (s_q.op == OP_BCD) ? w_in : file_rdata_in;
        s_d.fl    = flags_in;
        s_d.phase = PH_PROCESS;
      end
      PH_PROCESS:
      begin
        s_d.res      = alu_if.res;
        s_d.wdata    = alu_if.res;
        s_d.flags    = alu_if.fout;
        s_d.flags_we = (s_q.op == OP_CLR) || (s_q.op == OP_DEC) ||
                       (s_q.op == OP_BCD);
        s_d.w_we     = (s_q.op == OP_BCD) || (!s_q.dst_file &&
                       ((s_q.op == OP_DEC) || is_inc));
        s_d.file_we  = (s_q.op == OP_CLR) || (s_q.dst_file &&
                       ((s_q.op == OP_DEC) || is_inc));
        s_d.kick     = (s_q.op == OP_KICK);
        s_d.phase    = PH_WRITE;
      end
      PH_WRITE:
      begin
        if (s_q.flush)
          nskip = s_q.skip - `BXE_SKIP_ONE;
        else if (((s_q.op == OP_INCSZ) && (s_q.res == 8'h00)) ||
                 ((s_q.op == OP_INCSNZ) && (s_q.res != 8'h00)))
          nskip = next_two_word_in ? `BXE_SKIP_TWO : `BXE_SKIP_ONE;
        s_d.skip  = nskip;
        s_d.flush = (nskip != `BXE_SKIP_NONE);
        if (s_q.op == OP_KICK)
        begin
          s_d.timeout = 1'h1;
          s_d.sleep   = 1'h1;
        end
        s_d.phase = PH_DECODE;
      end
      default:
      begin
        s_d.phase = PH_DECODE;
      end
    endcase
  end

  always_ff @(posedge ref_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign file_addr_out      = s_q.addr;
  assign file_rd_out        = s_q.file_rd;
  assign file_we_out        = s_q.file_we;
  assign file_wdata_out     = s_q.wdata;
  assign w_we_out           = s_q.w_we;
  assign w_wdata_out        = s_q.wdata;
  assign flags_we_out       = s_q.flags_we;
  assign flags_out          = s_q.flags;
  assign watchdog_clear_out = s_q.kick;
  assign timeout_status_out = s_q.timeout;
  assign sleep_status_out   = s_q.sleep;
  assign flush_out          = s_q.flush;
  assign phase_out          = s_q.phase;

  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!rstn_in);

  property p_inc_route;
    (s_q.phase == PH_PROCESS && s_q.op == OP_INCSZ && !s_q.dst_file)
      |=> w_we_out && !file_we_out && w_wdata_out == s_q.opnd + 8'h01;
  endproperty
  a_inc_route: assert property (p_inc_route)
    else $error("increment result not routed to accumulator");

  property p_skip_zero;
    (s_q.phase == PH_WRITE && s_q.op == OP_INCSZ && s_q.res == 8'h00 &&
     !next_two_word_in) |=> flush_out[*4] ##1 !flush_out;
  endproperty
  a_skip_zero: assert property (p_skip_zero)
    else $error("zero result did not flush exactly one cycle");

  logic is_skip_now;
  assign is_skip_now = (s_q.op == OP_INCSZ && s_q.res == 8'h00) ||
                       (s_q.op == OP_INCSNZ && s_q.res != 8'h00);

  property p_skip_two;
    (s_q.phase == PH_WRITE && is_skip_now && next_two_word_in)
      |=> flush_out[*8] ##1 !flush_out;
  endproperty
  a_skip_two: assert property (p_skip_two)
    else $error("two-word skip did not flush two cycles");

  property p_access_bank;
    (s_q.phase == PH_DECODE && !instr_in[8])
      |=> file_addr_out[11:8] == `BXE_ACCESS_BANK &&
          file_addr_out[7:0] == $past(instr_in[7:0]);
  endproperty
  a_access_bank: assert property (p_access_bank)
    else $error("access bank not selected");

  property p_clr_phases;
    (s_q.phase == PH_DECODE && !s_q.flush && instr_valid_in &&
     instr_in[15:9] == `BXE_OPC_CLR)
      |=> file_rd_out ##2 file_we_out && file_wdata_out == 8'h00 &&
          flags_we_out && flags_out.z;
  endproperty
  a_clr_phases: assert property (p_clr_phases)
    else $error("clear did not read then write zero");

  property p_bcd_low;
    (s_q.phase == PH_PROCESS && s_q.op == OP_BCD &&
     s_q.opnd[3:0] > `BXE_BCD_LIMIT)
      |=> w_wdata_out[3:0] == $past(s_q.opnd[3:0]) + 4'h6;
  endproperty
  a_bcd_low: assert property (p_bcd_low)
    else $error("low nibble not adjusted by six");

  property p_bcd_example;
    (s_q.phase == PH_PROCESS && s_q.op == OP_BCD && s_q.opnd == 8'hCE &&
     !s_q.fl.c && !s_q.fl.half_carry)
      |=> w_wdata_out == 8'h34 && flags_out.c && !flags_out.half_carry;
  endproperty
  a_bcd_example: assert property (p_bcd_example)
    else $error("adjust of 0xCE wrong");

  property p_dec;
    (s_q.phase == PH_PROCESS && s_q.op == OP_DEC)
      |=> flags_we_out && w_wdata_out == $past(s_q.opnd) - 8'h01 &&
          flags_out.z == ($past(s_q.opnd) == 8'h01);
  endproperty
  a_dec: assert property (p_dec)
    else $error("decrement result or zero flag wrong");

  property p_kick;
    (s_q.phase == PH_PROCESS && s_q.op == OP_KICK)
      |=> watchdog_clear_out ##1 timeout_status_out && sleep_status_out;
  endproperty
  a_kick: assert property (p_kick)
    else $error("kick did not clear watchdog or set status");

  property p_skip_nonzero;
    (s_q.phase == PH_WRITE && s_q.op == OP_INCSNZ && s_q.res == 8'h00)
      |=> (!flush_out)[*4];
  endproperty
  a_skip_nonzero: assert property (p_skip_nonzero)
    else $error("zero result flushed on skip-nonzero");

  property p_inc_flags;
    (s_q.phase == PH_PROCESS && (s_q.op == OP_INCSZ ||
     s_q.op == OP_INCSNZ)) |=> !flags_we_out;
  endproperty
  a_inc_flags: assert property (p_inc_flags)
    else $error("increment-skip touched status flags");

endmodule // bxe_exec

/* File: dv/test_byte_op_instruction_exec.sv */
// Self-checking bench for the byte-op executor, driving every input.
// Assumes bxe_pkg and bxe_defs.svh from src/ are on the compile path.
`timescale 1ns/100ps
`include "bxe_defs.svh"
module test_byte_op_instruction_exec;
  import bxe_pkg::*;
  logic        ref_clk_in, rstn_in, instr_valid_in, next_two_word_in;
  logic [15:0] instr_in;
  logic [3:0]  bank_select_in;
  logic [7:0]  w_in, file_rdata_in, file_wdata_out, w_wdata_out;
  bxe_flags_t  flags_in, flags_out;
  logic [11:0] file_addr_out, addr_seen;
  logic        file_rd_out, file_we_out, w_we_out, flags_we_out;
  logic        watchdog_clear_out, timeout_status_out, sleep_status_out;
  logic        flush_out;
  bxe_phase_t  phase_out;
  int          num_errors = 0;
  int          cmp_count = 0;

  bxe_exec u_dut (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in),
    .instr_in(instr_in), .instr_valid_in(instr_valid_in),
    .next_two_word_in(next_two_word_in), .bank_select_in(bank_select_in),
    .w_in(w_in), .file_rdata_in(file_rdata_in), .flags_in(flags_in),
    .file_addr_out(file_addr_out), .file_rd_out(file_rd_out),
    .file_we_out(file_we_out), .file_wdata_out(file_wdata_out),
    .w_we_out(w_we_out), .w_wdata_out(w_wdata_out),
    .flags_we_out(flags_we_out), .flags_out(flags_out),
    .watchdog_clear_out(watchdog_clear_out),
    .timeout_status_out(timeout_status_out),
    .sleep_status_out(sleep_status_out), .flush_out(flush_out),
    .phase_out(phase_out));

  initial
  begin
    ref_clk_in = 1'h0;
    forever #10 ref_clk_in = ~ref_clk_in;
  end

  task automatic chk(input string nm, input logic [15:0] seen,
                     input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic tick;
    @(posedge ref_clk_in);
    #2;
  endtask

  // Waits for a free decode slot, then runs one instruction up to its write
  // phase and returns there.
  task automatic issue(input logic [15:0] ins, input logic [7:0] rd,
                       input logic rd_exp);
    int n;
    n = 0;
    while (!(phase_out === PH_DECODE && flush_out === 1'h0) && n < 40)
    begin
      tick();
      n++;
    end
    chk("slot_wait", 16'(n == 40), 16'h0000);
    instr_in = ins;
    instr_valid_in = 1'h1;
    file_rdata_in = rd;
    tick();
    instr_valid_in = 1'h0;
    chk("phase_read", phase_out, PH_READ);
    chk("file_rd", file_rd_out, rd_exp);
    addr_seen = file_addr_out;
    tick();
    chk("phase_proc", phase_out, PH_PROCESS);
    tick();
    chk("phase_write", phase_out, PH_WRITE);
  endtask

  task automatic wchk(input logic fwe, input logic wwe, input logic [7:0] d,
                      input logic fl_we, input bxe_flags_t fl);
    chk("file_we", file_we_out, fwe);
    chk("w_we", w_we_out, wwe);
    if (fwe | wwe)
      chk("wdata", fwe ? file_wdata_out : w_wdata_out, d);
    chk("flags_we", flags_we_out, fl_we);
    if (fl_we)
      chk("flags", flags_out, fl);
  endtask

  task automatic t_clear;
    bank_select_in = 4'h5;
    flags_in = 5'h11;
    issue({`BXE_OPC_CLR, 1'h0, 8'h21}, 8'h77, 1'h1);
    chk("clr_addr_acc", addr_seen, 12'h021);
    wchk(1'h1, 1'h0, 8'h00, 1'h1, 5'h15);
    issue({`BXE_OPC_CLR, 1'h1, 8'h21}, 8'h77, 1'h1);
    chk("clr_addr_bank", addr_seen, 12'h521);
    wchk(1'h1, 1'h0, 8'h00, 1'h1, 5'h15);
    $display("test clear done");
  endtask

  task automatic t_kick;
    chk("timeout_pre", timeout_status_out, 1'h0);
    issue(`BXE_INSN_KICK, 8'h00, 1'h0);
    chk("watchdog_clear", watchdog_clear_out, 1'h1);
    wchk(1'h0, 1'h0, 8'h00, 1'h0, 5'h00);
    tick();
    chk("timeout", timeout_status_out, 1'h1);
    chk("sleep", sleep_status_out, 1'h1);
    $display("test kick done");
  endtask

  // Mid-run reset must drop the sticky status levels and restart decode.
  task automatic t_reset;
    rstn_in = 1'h0;
    tick();
    chk("rst_timeout", timeout_status_out, 1'h0);
    chk("rst_sleep", sleep_status_out, 1'h0);
    chk("rst_phase", phase_out, PH_DECODE);
    chk("rst_flush", flush_out, 1'h0);
    rstn_in = 1'h1;
    $display("test reset done");
  endtask

  task automatic t_bcd;
    logic [7:0] bw [5] = '{8'hA5, 8'hCE, 8'h12, 8'h0A, 8'h12};
    logic [7:0] bx [5] = '{8'h05, 8'h34, 8'h12, 8'h10, 8'h78};
    logic [4:0] bi [5] = '{5'h00, 5'h00, 5'h00, 5'h00, 5'h03};
    logic [4:0] bf [5] = '{5'h01, 5'h01, 5'h00, 5'h00, 5'h03};
    for (int i = 0; i < 5; i++)
    begin
      w_in = bw[i];
      flags_in = bi[i];
      issue(`BXE_INSN_BCD, 8'h00, 1'h0);
      wchk(1'h0, 1'h1, bx[i], 1'h1, bf[i]);
    end
    $display("test bcd adjust done");
  endtask

  task automatic t_dec;
    logic [7:0] dv [4] = '{8'h00, 8'h01, 8'h80, 8'h10};
    logic [7:0] dx [4] = '{8'hFF, 8'h00, 8'h7F, 8'h0F};
    logic [4:0] df [4] = '{5'h10, 5'h07, 5'h09, 5'h01};
    flags_in = 5'h0A;
    for (int i = 0; i < 4; i++)
    begin
      issue({`BXE_OPC_DEC, i[0], 1'h0, 8'h30}, dv[i], 1'h1);
      wchk(i[0], !i[0], dx[i], 1'h1, df[i]);
    end
    $display("test decrement done");
  endtask

  task automatic t_inc;
    logic [5:0] op;
    logic [7:0] rd, res;
    logic       skip, rdx;
    int         n;
    logic [15:0] fexp;
    flags_in = 5'h0A;
    for (int k = 0; k < 8; k++)
    begin
      op = k[2] ? `BXE_OPC_INCSNZ : `BXE_OPC_INCSZ;
      rd = k[1] ? 8'h3F : 8'hFF;
      res = rd + 8'h01;
      skip = k[2] ? (res != 8'h00) : (res == 8'h00);
      next_two_word_in = k[0];
      issue({op, k[0], 1'h1, 8'h44}, rd, 1'h1);
      chk("inc_addr", addr_seen, {4'h5, 8'h44});
      wchk(k[0], !k[0], res, 1'h0, 5'h00);
      // A clear is offered throughout the flush; it must not be taken.
      instr_in = {`BXE_OPC_CLR, 1'h0, 8'h01};
      instr_valid_in = 1'h1;
      n = 0;
      rdx = 1'h0;
      tick();
      while (flush_out === 1'h1 && n < 20)
      begin
        n++;
        rdx = rdx | file_rd_out | file_we_out;
        tick();
      end
      instr_valid_in = 1'h0;
      fexp = skip ? (k[0] ? 16'h0008 : 16'h0004) : 16'h0000;
      chk("flush_len", 16'(n), fexp);
      chk("flush_idle", rdx, 1'h0);
    end
    $display("test increment skip done");
  endtask

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial
  begin
    rstn_in = 1'h0;
    instr_in = 16'h0000;
    instr_valid_in = 1'h0;
    next_two_word_in = 1'h0;
    bank_select_in = 4'h0;
    w_in = 8'h00;
    file_rdata_in = 8'h00;
    flags_in = 5'h00;
    repeat (10) @(posedge ref_clk_in);
    #2;
    rstn_in = 1'h1;
    t_clear();
    t_kick();
    t_reset();
    t_bcd();
    t_dec();
    t_inc();
    end_sim();
  end

  initial
  begin
    repeat (2000) @(posedge ref_clk_in);
    num_errors++;
    end_sim();
  end
endmodule // test_byte_op_instruction_exec
